// file: hw/vp_valve_pump.v
/*
  Valve PWM driver with PI current loop and dither, plus pump contactor
  driver with pull-in, hold and battery compensation, behind an APB slave.
  Assumes throttle, valve current and battery voltage arrive as synchronous
  samples on the system clock; PWM outputs drive external power stages.
*/
// Our own choice: register access over APB.
// Contract
// - Loop select on means PI loop sets valve duty, off means software duty.
// - Lower source on takes throttle, off takes software lower command.
// - Valve current ceiling 0 to 607 raw limits maximum valve opening.
// - Valve current floor 0 to 607 raw keeps valve ready to open.
// - Dither adds then subtracts amplitude percent of ceiling, 32767 full.
// - Dither period code 1 to 7 gives 16 to 112 ms.
// - Proportional gain 82 to 8192 scales current error.
// - Integral gain 327 to 32767 accumulates error to remove steady error.
// - Pump mode on: start closes contactor with pull-in then hold; stop opens.
// - Pump mode off: start and stop ignored, driver 3 software controlled.
// - Contactor output pull-in level first, hold level after 1 second.
// - Hold level reduces average coil level; both levels 0 to 32767.
// - Pull-in and hold levels scale inversely with measured battery voltage.
`include "vp_consts.vh"

module vp_valve_pump #(
  parameter P_TICK_CYCLES = `VP_TICK_US * `VP_CLK_MHZ
) (
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [15:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire [15:0] i_throttle_pos,
  input wire [15:0] i_valve_current,
  input wire [15:0] i_battery_volt,
  output wire o_valve_driver_channel,
  output wire o_coil_driver
);

  localparam ST_OFF = 3'b001;
  localparam ST_PULLIN = 3'b010;
  localparam ST_HOLD = 3'b100;

  // Reset release through two flops; assertion stays asynchronous
  reg rst_q1;
  reg rst_n;
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Register id from byte address; zero marks an unmapped word
  function [4:0] reg_id;
    input [15:0] addr;
    begin
      reg_id = 5'd0;
      if (addr[1:0] == 2'b00) begin
        case (addr[15:2])
          `VP_IDX_CEIL: reg_id = 5'd1;
          `VP_IDX_FLOOR: reg_id = 5'd2;
          `VP_IDX_DITH_AMP: reg_id = 5'd3;
          `VP_IDX_DITH_PER: reg_id = 5'd4;
          `VP_IDX_KP: reg_id = 5'd5;
          `VP_IDX_KI: reg_id = 5'd6;
          `VP_IDX_OPT_A: reg_id = 5'd7;
          `VP_IDX_OPT_D: reg_id = 5'd8;
          `VP_IDX_PULLIN: reg_id = 5'd9;
          `VP_IDX_HOLD: reg_id = 5'd10;
          `VP_IDX_CMD: reg_id = 5'd11;
          `VP_IDX_APP_LOWER: reg_id = 5'd12;
          `VP_IDX_APP_VALVE: reg_id = 5'd13;
          `VP_IDX_APP_DRV3: reg_id = 5'd14;
          `VP_IDX_STATUS: reg_id = 5'd15;
          `VP_IDX_VALVE_DUTY: reg_id = 5'd16;
          `VP_IDX_COIL_DUTY: reg_id = 5'd17;
          `VP_IDX_SETPOINT: reg_id = 5'd18;
          default: reg_id = 5'd0;
        endcase
      end
    end
  endfunction

  // Saturate a signed value into 0..hi
  function [15:0] sat;
    input signed [35:0] v;
    input [15:0] hi;
    begin
      if (v < 36'sd0)
        sat = 16'h0000;
      else if (v > $signed({20'd0, hi}))
        sat = hi;
      else
        sat = v[15:0];
    end
  endfunction

  reg [15:0] ceil_reg;
  reg [15:0] floor_reg;
  reg [15:0] dith_amp;
  reg [15:0] dith_per;
  reg [15:0] kp;
  reg [15:0] ki;
  reg [15:0] opt_a;
  reg [15:0] opt_d;
  reg [15:0] pullin_lvl;
  reg [15:0] hold_lvl;
  reg [15:0] app_lower;
  reg [15:0] app_valve;
  reg [15:0] app_drv3;
  reg [31:0] prdata;
  reg start_req;
  reg stop_req;
  reg [15:0] valve_duty;
  reg [15:0] coil_duty;
  reg [15:0] setpoint;
  reg [2:0] coil_st;

  wire [4:0] id = reg_id(i_paddr);
  wire wr_en = i_psel & i_penable & i_pwrite;
  wire rd_setup = i_psel & ~i_penable & ~i_pwrite;
  wire loop_sel = opt_a[`VP_BIT_LOOP_SEL];
  wire lower_src = opt_a[`VP_BIT_LOWER_SRC];
  wire pump_mode = opt_d[`VP_BIT_PUMP_MODE];

  // Zero wait states; unmapped words answer with an error
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & (id == 5'd0);
  assign o_prdata = prdata;

  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ceil_reg <= `VP_RST_ZERO;
      floor_reg <= `VP_RST_ZERO;
      dith_amp <= `VP_RST_ZERO;
      dith_per <= `VP_RST_DITH_PER;
      kp <= `VP_RST_KP;
      ki <= `VP_RST_KI;
      opt_a <= `VP_RST_ZERO;
      opt_d <= `VP_RST_ZERO;
      pullin_lvl <= `VP_RST_ZERO;
      hold_lvl <= `VP_RST_ZERO;
      app_lower <= `VP_RST_ZERO;
      app_valve <= `VP_RST_ZERO;
      app_drv3 <= `VP_RST_ZERO;
      start_req <= 1'b0;
      stop_req <= 1'b0;
    end else begin
      start_req <= 1'b0;
      stop_req <= 1'b0;
      if (wr_en) begin
        case (id)
          5'd1: ceil_reg <= i_pwdata[15:0];
          5'd2: floor_reg <= i_pwdata[15:0];
          5'd3: dith_amp <= i_pwdata[15:0];
          5'd4: dith_per <= i_pwdata[15:0];
          5'd5: kp <= i_pwdata[15:0];
          5'd6: ki <= i_pwdata[15:0];
          5'd7: opt_a <= i_pwdata[15:0];
          5'd8: opt_d <= i_pwdata[15:0];
          5'd9: pullin_lvl <= i_pwdata[15:0];
          5'd10: hold_lvl <= i_pwdata[15:0];
          5'd11: begin
            start_req <= i_pwdata[`VP_BIT_CMD_START];
            stop_req <= i_pwdata[`VP_BIT_CMD_STOP];
          end
          5'd12: app_lower <= i_pwdata[15:0];
          5'd13: app_valve <= i_pwdata[15:0];
          5'd14: app_drv3 <= i_pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // Read data is captured in the setup phase so it comes from a flop
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (id)
        5'd1: prdata <= {16'h0000, ceil_reg};
        5'd2: prdata <= {16'h0000, floor_reg};
        5'd3: prdata <= {16'h0000, dith_amp};
        5'd4: prdata <= {16'h0000, dith_per};
        5'd5: prdata <= {16'h0000, kp};
        5'd6: prdata <= {16'h0000, ki};
        5'd7: prdata <= {16'h0000, opt_a};
        5'd8: prdata <= {16'h0000, opt_d};
        5'd9: prdata <= {16'h0000, pullin_lvl};
        5'd10: prdata <= {16'h0000, hold_lvl};
        5'd12: prdata <= {16'h0000, app_lower};
        5'd13: prdata <= {16'h0000, app_valve};
        5'd14: prdata <= {16'h0000, app_drv3};
        5'd15: prdata <= {29'd0, coil_st};
        5'd16: prdata <= {16'h0000, valve_duty};
        5'd17: prdata <= {16'h0000, coil_duty};
        5'd18: prdata <= {16'h0000, setpoint};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control tick, one millisecond
  reg [16:0] tick_cnt;
  wire tick = (tick_cnt == P_TICK_CYCLES - 1);
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n)
      tick_cnt <= 17'd0;
    else if (tick)
      tick_cnt <= 17'd0;
    else
      tick_cnt <= tick_cnt + 17'd1;
  end

  // Setpoint path: demand scaled by ceiling, then clamped
  wire [15:0] ceil_eff = (ceil_reg > `VP_CUR_MAX) ? `VP_CUR_MAX : ceil_reg;
  wire [15:0] floor_eff = (floor_reg > ceil_eff) ? ceil_eff : floor_reg;
  wire [15:0] demand = lower_src ? i_throttle_pos : app_lower;
  wire [15:0] demand_c = (demand > `VP_DUTY_MAX) ? `VP_DUTY_MAX : demand;
  wire [31:0] raw_prod = demand_c * ceil_eff;
  wire [15:0] raw_sp = raw_prod[30:15];
  reg [15:0] next_setpoint;
  always @* begin
    next_setpoint = raw_sp;
    if (raw_sp < floor_eff)
      next_setpoint = floor_eff;
    else if (raw_sp > ceil_eff)
      next_setpoint = ceil_eff;
  end

  // Dither amplitude as a fraction of the ceiling
  wire [15:0] amp_c = (dith_amp > `VP_DUTY_MAX) ? `VP_DUTY_MAX : dith_amp;
  wire [31:0] amp_prod = amp_c * ceil_eff;
  wire [15:0] dith_size = amp_prod[30:15];

  // Half period in ticks; code zero behaves as code one
  wire [2:0] per_code = dith_per[2:0] & `VP_DITH_PER_MASK;
  wire [2:0] per_eff = (per_code == 3'd0) ? 3'd1 : per_code;
  wire [31:0] half_full = per_eff * (`VP_DITH_STEP_MS / 2);
  wire [7:0] half_ticks = half_full[7:0];
  reg [7:0] dith_cnt;
  reg dith_up;
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dith_cnt <= 8'd0;
      dith_up <= 1'b1;
    end else if (tick) begin
      if (dith_cnt >= half_ticks - 8'd1) begin
        dith_cnt <= 8'd0;
        dith_up <= ~dith_up;
      end else begin
        dith_cnt <= dith_cnt + 8'd1;
      end
    end
  end

  // Dithered target may dip below zero near a small setpoint
  wire signed [17:0] target = dith_up ?
    $signed({2'b00, setpoint}) + $signed({2'b00, dith_size}) :
    $signed({2'b00, setpoint}) - $signed({2'b00, dith_size});
  wire signed [17:0] err = target - $signed({2'b00, i_valve_current});
  wire signed [35:0] p_term = (err * $signed({2'b00, kp})) >>> `VP_KP_SHIFT;
  wire signed [35:0] i_step = (err * $signed({2'b00, ki})) >>> `VP_FRAC_SHIFT;
  reg [15:0] integ;
  wire signed [35:0] integ_sum = $signed({20'd0, integ}) + i_step;
  wire signed [35:0] pi_sum = p_term + $signed({20'd0, integ});

  // Integrator saturates at the duty range to avoid windup
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      integ <= 16'h0000;
      setpoint <= 16'h0000;
      valve_duty <= 16'h0000;
    end else if (tick) begin
      setpoint <= next_setpoint;
      if (loop_sel) begin
        integ <= sat(integ_sum, `VP_DUTY_MAX);
        valve_duty <= sat(pi_sum, `VP_DUTY_MAX);
      end else begin
        integ <= 16'h0000;
        valve_duty <= (app_valve > `VP_DUTY_MAX) ? `VP_DUTY_MAX : app_valve;
      end
    end
  end

  // Contactor sequencing; a stop in the same cycle as a start wins
  reg [2:0] next_coil_st;
  reg [9:0] pull_cnt;
  wire pull_done = (pull_cnt == `VP_PULLIN_MS - 1) & tick;
  always @* begin
    next_coil_st = coil_st;
    case (coil_st)
      ST_OFF: if (start_req && !stop_req) next_coil_st = ST_PULLIN;
      ST_PULLIN: begin
        if (stop_req)
          next_coil_st = ST_OFF;
        else if (pull_done)
          next_coil_st = ST_HOLD;
      end
      ST_HOLD: if (stop_req) next_coil_st = ST_OFF;
      default: next_coil_st = ST_OFF;
    endcase
    if (!pump_mode)
      next_coil_st = ST_OFF;
  end

  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      coil_st <= ST_OFF;
      pull_cnt <= 10'd0;
    end else begin
      coil_st <= next_coil_st;
      if (next_coil_st != ST_PULLIN)
        pull_cnt <= 10'd0;
      else if (tick && coil_st == ST_PULLIN)
        pull_cnt <= pull_cnt + 10'd1;
    end
  end

  // Compensation: level times nominal over measured battery voltage
  wire [15:0] lvl = (coil_st == ST_PULLIN) ? pullin_lvl : hold_lvl;
  wire [31:0] lvl_num = lvl * `VP_VBAT_NOMINAL;
  wire [31:0] lvl_q = (i_battery_volt == 16'h0000) ? {16'h0000, `VP_DUTY_MAX} :
    lvl_num / {16'h0000, i_battery_volt};
  wire [15:0] lvl_comp = (lvl_q > {16'h0000, `VP_DUTY_MAX}) ? `VP_DUTY_MAX : lvl_q[15:0];
  reg [15:0] next_coil_duty;
  always @* begin
    if (!pump_mode)
      next_coil_duty = (app_drv3 > `VP_DUTY_MAX) ? `VP_DUTY_MAX : app_drv3;
    else if (coil_st == ST_OFF)
      next_coil_duty = 16'h0000;
    else
      next_coil_duty = lvl_comp;
  end

  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n)
      coil_duty <= 16'h0000;
    else
      coil_duty <= next_coil_duty;
  end

  // Shared PWM carrier; full scale 32767 leaves one low cycle per period
  reg [14:0] pwm_cnt;
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n)
      pwm_cnt <= 15'd0;
    else
      pwm_cnt <= pwm_cnt + 15'd1;
  end

  wire [31:0] duty_bus = {coil_duty, valve_duty};
  reg [1:0] pwm_q;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pwm
      always @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n)
          pwm_q[g] <= 1'b0;
        else
          pwm_q[g] <= ({1'b0, pwm_cnt} < duty_bus[g*16 +: 16]);
      end
    end
  endgenerate

  assign o_valve_driver_channel = pwm_q[0];
  assign o_coil_driver = pwm_q[1];

endmodule // vp_valve_pump

// file: include/vp_consts.vh
/*
  Constants for the valve PWM and pump contactor block: register indices,
  field positions, reset values and timing counts.
  Assumes a 100 MHz system clock and 32-bit APB with one word per register.
*/
`ifndef VP_CONSTS_VH
`define VP_CONSTS_VH

// Register indices; byte address is four times the index
`define VP_IDX_CEIL 14'h3040
`define VP_IDX_FLOOR 14'h3041
`define VP_IDX_DITH_AMP 14'h3042
`define VP_IDX_DITH_PER 14'h3043
`define VP_IDX_KP 14'h3044
`define VP_IDX_KI 14'h3045
`define VP_IDX_OPT_A 14'h306a
`define VP_IDX_OPT_D 14'h306d
`define VP_IDX_PULLIN 14'h3864
`define VP_IDX_HOLD 14'h3865
`define VP_IDX_CMD 14'h3a00
`define VP_IDX_APP_LOWER 14'h3a01
`define VP_IDX_APP_VALVE 14'h3a02
`define VP_IDX_APP_DRV3 14'h3a03
`define VP_IDX_STATUS 14'h3a04
`define VP_IDX_VALVE_DUTY 14'h3a05
`define VP_IDX_COIL_DUTY 14'h3a06
`define VP_IDX_SETPOINT 14'h3a07

// Field positions
`define VP_BIT_LOOP_SEL 6
`define VP_BIT_LOWER_SRC 7
`define VP_BIT_PUMP_MODE 1
`define VP_BIT_CMD_START 0
`define VP_BIT_CMD_STOP 1

// Reset values
`define VP_RST_ZERO 16'h0000
`define VP_RST_DITH_PER 16'h0001
`define VP_RST_KP 16'h0052
`define VP_RST_KI 16'h0147

// Limits and scaling
`define VP_CUR_MAX 16'h025f
`define VP_DUTY_MAX 16'h7fff
`define VP_KP_SHIFT 13
`define VP_FRAC_SHIFT 15
`define VP_VBAT_NOMINAL 16'h1000
`define VP_DITH_STEP_MS 16
`define VP_DITH_PER_MASK 3'h7

// Timing
`define VP_CLK_MHZ 100
`define VP_TICK_US 1000
`define VP_PULLIN_MS 1000

`endif

// file: testbench/test_valve_pwm_and_pump_contactor.sv
/* Bench for the valve and pump block: APB master tasks, one task per scenario.
   Assumes vp_consts.vh on the include path and a 100 MHz clock. */
`include "vp_consts.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module test_valve_pwm_and_pump_contactor;
  timeunit 1ns;
  timeprecision 1ps;
  // Short tick keeps the one second pull-in near 10000 clocks
  localparam int TK = 10;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, open_c = 0;
  logic [15:0] paddr = 0, thr = 0, vbat = 16'h1000, cur, chigh;
  logic [31:0] pwd = 0, prd, rd;
  logic prdy, perr, vpwm, cpwm;
  int npul, miscompares = 0, check_count = 0, cyc = 0;
  always #5 clk = ~clk;
  vp_valve_pump #(.P_TICK_CYCLES(TK)) dut (.i_sys_clk(clk), .i_arst_n(rst_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr), .i_throttle_pos(thr),
    .i_valve_current(cur), .i_battery_volt(vbat), .o_valve_driver_channel(vpwm),
    .o_coil_driver(cpwm));
  vp_coil_model coil (.i_clk(clk), .i_valve_pwm(vpwm), .i_coil_pwm(cpwm),
    .i_coil_open(open_c), .o_valve_current(cur), .o_coil_high(chigh), .o_pulses(npul));
  task automatic apb(input logic w, input logic [15:0] a, input logic [15:0] d,
      input logic err);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= {16'h0000, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    rd = prd;
    `CHK("pslverr", err, perr)
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [13:0] i, input logic [15:0] d);
    apb(1'b1, {i, 2'b00}, d, 1'b0);
  endtask
  task automatic rc(input string n, input logic [13:0] i, input logic [15:0] e);
    apb(1'b0, {i, 2'b00}, 16'h0000, 1'b0);
    `CHK(n, {16'h0000, e}, rd)
  endtask
  task automatic tk(input int n);
    repeat (n * TK) @(posedge clk);
  endtask
  task automatic t_regs;
    rc("dither_period", `VP_IDX_DITH_PER, `VP_RST_DITH_PER);
    rc("kp", `VP_IDX_KP, `VP_RST_KP);
    rc("ki", `VP_IDX_KI, `VP_RST_KI);
    rc("ceiling", `VP_IDX_CEIL, `VP_RST_ZERO);
    rc("status", `VP_IDX_STATUS, 16'h0001);
    wr(`VP_IDX_KP, 16'h1fff);
    rc("kp", `VP_IDX_KP, 16'h1fff);
    apb(1'b0, 16'hfff0, 16'h0000, 1'b1);
    `CHK("unmapped", 32'h0000_0000, rd)
    apb(1'b1, 16'hc106, 16'h0005, 1'b1);
    rc("floor", `VP_IDX_FLOOR, `VP_RST_ZERO);
    $display("regs done");
  endtask
  task automatic t_setpt;
    wr(`VP_IDX_DITH_AMP, 16'h0000);
    wr(`VP_IDX_OPT_A, 16'h0080);
    wr(`VP_IDX_CEIL, 16'h0190);
    wr(`VP_IDX_FLOOR, 16'h0064);
    thr <= 16'h7fff;
    tk(3);
    rc("setpoint", `VP_IDX_SETPOINT, 16'h018f);
    thr <= 16'h0000;
    tk(3);
    rc("setpoint", `VP_IDX_SETPOINT, 16'h0064);
    wr(`VP_IDX_OPT_A, 16'h0000);
    wr(`VP_IDX_APP_LOWER, 16'h4000);
    tk(3);
    rc("setpoint", `VP_IDX_SETPOINT, 16'h00c8);
    wr(`VP_IDX_CEIL, 16'h0300);
    wr(`VP_IDX_APP_LOWER, 16'h7fff);
    tk(3);
    rc("setpoint", `VP_IDX_SETPOINT, 16'h025e);
    $display("setpoint done");
  endtask
  task automatic t_valve;
    logic [15:0] d1;
    wr(`VP_IDX_CEIL, 16'h0190);
    wr(`VP_IDX_FLOOR, 16'h0000);
    wr(`VP_IDX_APP_LOWER, 16'h4000);
    wr(`VP_IDX_APP_VALVE, 16'h1234);
    tk(2);
    rc("valve_duty", `VP_IDX_VALVE_DUTY, 16'h1234);
    open_c <= 1'b1;
    wr(`VP_IDX_KP, 16'h2000);
    wr(`VP_IDX_KI, 16'h0000);
    wr(`VP_IDX_OPT_A, 16'h0040);
    tk(3);
    rc("valve_duty", `VP_IDX_VALVE_DUTY, 16'h00c8);
    wr(`VP_IDX_KP, 16'h0000);
    wr(`VP_IDX_KI, 16'h4000);
    tk(2);
    apb(1'b0, {`VP_IDX_VALVE_DUTY, 2'b00}, 16'h0000, 1'b0);
    d1 = rd[15:0];
    repeat (TK - 3) @(posedge clk);
    rc("valve_duty", `VP_IDX_VALVE_DUTY, d1 + 16'h0064);
    $display("valve done");
  endtask
  task automatic t_dither;
    int n;
    logic [15:0] d0;
    wr(`VP_IDX_OPT_A, 16'h0000);
    tk(2);
    wr(`VP_IDX_KI, 16'h0000);
    wr(`VP_IDX_KP, 16'h2000);
    wr(`VP_IDX_OPT_A, 16'h0040);
    wr(`VP_IDX_DITH_AMP, 16'h4000);
    for (int c = 1; c < 8; c++) begin
      wr(`VP_IDX_DITH_PER, 16'(c));
      apb(1'b0, {`VP_IDX_VALVE_DUTY, 2'b00}, 16'h0000, 1'b0);
      // First change may end a half begun under the old code
      // Reads stay one tick apart so a half is counted without phase slip
      for (int k = 0; k < 2; k++) begin
        d0 = rd[15:0];
        n = 0;
        do begin
          repeat (TK - 3) @(posedge clk);
          apb(1'b0, {`VP_IDX_VALVE_DUTY, 2'b00}, 16'h0000, 1'b0);
          n++;
        end while (rd[15:0] === d0);
      end
      `CHK("dither_half", 8 * c, n)
      `CHK("dither_swing", 16'h0190, d0 + rd[15:0])
    end
    $display("dither done");
  endtask
  task automatic t_pump;
    int n;
    wr(`VP_IDX_OPT_A, 16'h0000);
    wr(`VP_IDX_APP_VALVE, 16'h1234);
    open_c <= 1'b0;
    wr(`VP_IDX_PULLIN, 16'h6000);
    wr(`VP_IDX_HOLD, 16'h2000);
    wr(`VP_IDX_APP_DRV3, 16'h0100);
    wr(`VP_IDX_CMD, 16'h0001);
    tk(2);
    rc("status", `VP_IDX_STATUS, 16'h0001);
    rc("coil_duty", `VP_IDX_COIL_DUTY, 16'h0100);
    vbat <= 16'h2000;
    wr(`VP_IDX_OPT_D, 16'h0002);
    wr(`VP_IDX_CMD, 16'h0001);
    tk(3);
    rc("status", `VP_IDX_STATUS, 16'h0002);
    rc("coil_duty", `VP_IDX_COIL_DUTY, 16'h3000);
    tk(990);
    rc("status", `VP_IDX_STATUS, 16'h0002);
    tk(12);
    rc("status", `VP_IDX_STATUS, 16'h0004);
    rc("coil_duty", `VP_IDX_COIL_DUTY, 16'h1000);
    n = npul;
    while (npul < n + 2) @(posedge clk);
    `CHK("coil_high", 16'h1000, chigh)
    // Valve pulse of this carrier period ends after the coil pulse
    repeat (16'h0300) @(posedge clk);
    `CHK("valve_current", 16'h0056, cur)
    wr(`VP_IDX_CMD, 16'h0003);
    tk(2);
    rc("status", `VP_IDX_STATUS, 16'h0001);
    rc("coil_duty", `VP_IDX_COIL_DUTY, 16'h0000);
    $display("pump done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Tests need about 70000 clocks
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_setpt();
    t_valve();
    t_dither();
    t_pump();
    summarize();
  end
endmodule // test_valve_pwm_and_pump_contactor
bind vp_valve_pump vp_valve_pump_chk chk (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_throttle_pos(i_throttle_pos), .i_valve_current(i_valve_current),
  .i_battery_volt(i_battery_volt), .o_valve_driver_channel(o_valve_driver_channel),
  .o_coil_driver(o_coil_driver));

// file: testbench/vp_coil_model.sv
/* Valve coil and contactor coil model: current from pulse width, pulse monitor.
   Assumes PWM period of 32768 clocks; current is a steady-state estimate. */
module vp_coil_model (
  input wire logic i_clk,
  input wire logic i_valve_pwm,
  input wire logic i_coil_pwm,
  input wire logic i_coil_open,
  output logic [15:0] o_valve_current,
  output logic [15:0] o_coil_high,
  output int o_pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] vcnt = 16'h0000, ccnt = 16'h0000, vlast = 16'h0000;
  initial begin
    o_coil_high = 16'h0000;
    o_pulses = 0;
  end
  // Broken coil carries no current whatever the duty
  assign o_valve_current = i_coil_open ? 16'h0000 : 16'((32'(vlast) * 607) >> 15);
  always @(posedge i_clk) begin
    vcnt <= i_valve_pwm ? vcnt + 16'h0001 : 16'h0000;
    if (!i_valve_pwm && vcnt != 16'h0000) vlast <= vcnt;
    ccnt <= i_coil_pwm ? ccnt + 16'h0001 : 16'h0000;
    if (!i_coil_pwm && ccnt != 16'h0000) begin
      o_coil_high <= ccnt;
      o_pulses <= o_pulses + 1;
    end
  end
endmodule // vp_coil_model

// file: testbench/vp_valve_pump_chk.sv
/* Checker for the valve and pump block: APB answer, error and read data.
   Assumes it is bound to the top module and sees only its ports. */
`include "vp_consts.vh"
module vp_valve_pump_chk (
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [15:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire [15:0] i_throttle_pos,
  input wire [15:0] i_valve_current,
  input wire [15:0] i_battery_volt,
  input wire o_valve_driver_channel,
  input wire o_coil_driver
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);
  wire [13:0] idx = i_paddr[15:2];
  wire mapped = (idx >= `VP_IDX_CEIL && idx <= `VP_IDX_KI) || idx == `VP_IDX_OPT_A ||
    idx == `VP_IDX_OPT_D || idx == `VP_IDX_PULLIN || idx == `VP_IDX_HOLD ||
    (idx >= `VP_IDX_CMD && idx <= `VP_IDX_SETPOINT);
  // Only a few plain stored words; capped limits also read back as written
  wire echo = idx == `VP_IDX_KP || idx == `VP_IDX_KI || idx == `VP_IDX_HOLD;
  sequence s_acc;
    i_psel && i_penable;
  endsequence
  sequence s_rd_setup;
    i_psel && !i_penable && !i_pwrite;
  endsequence
  sequence s_wr_acc;
    i_psel && i_penable && i_pwrite && echo;
  endsequence
  AST_PREADY: assert property (o_pready)
    else $error("pready low");
  AST_ERR_IDLE: assert property (!(i_psel && i_penable) |-> !o_pslverr)
    else $error("pslverr outside access");
  AST_ERR_MAP: assert property (s_acc |-> o_pslverr == (!mapped || i_paddr[1:0] != 2'b00))
    else $error("pslverr wrong for address");
  AST_RD_ERR_ZERO: assert property (i_psel && i_penable && !i_pwrite && o_pslverr
    |-> o_prdata == 32'h0000_0000) else $error("refused read not zero");
  AST_RD_HI_ZERO: assert property (i_psel && i_penable && !i_pwrite
    |-> o_prdata[31:16] == 16'h0000) else $error("read upper half not zero");
  AST_RD_HOLD: assert property (!(i_psel && !i_penable && !i_pwrite) |=> $stable(o_prdata))
    else $error("read data moved");
  AST_RST_QUIET: assert property ($rose(i_arst_n) |-> (o_prdata == 32'h0000_0000 &&
    !o_coil_driver && !o_valve_driver_channel) [*2]) else $error("outputs busy after reset");
  AST_RW_ECHO: assert property (s_wr_acc ##2 s_rd_setup ##1 s_acc |-> i_paddr != $past(i_paddr, 3)
    || o_prdata[15:0] == $past(i_pwdata[15:0], 3)) else $error("readback differs");
endmodule // vp_valve_pump_chk
